// file: nmc_pkg.sv
package nmc_pkg;

    // ****************************************
    // Frame shape
    // ****************************************
    localparam int ID_W = 11;
    localparam int DATA_W = 64;
    localparam int NODE_W = 6;

    // ****************************************
    // Identifiers and command codes
    // ****************************************
    localparam logic [10:0] CMD_BASE = 11'h140;
    localparam logic [10:0] RPL_BASE = 11'h240;
    localparam logic [10:0] MOT_BASE = 11'h400;
    localparam logic [10:0] MOT_RPL_BASE = 11'h500;
    localparam logic [7:0] NODE_CMD = 8'h79;
    localparam logic [7:0] RW_READ = 8'h01;
    localparam logic [7:0] RW_WRITE = 8'h00;
    localparam logic [5:0] NODE_MIN = 6'h01;
    localparam logic [5:0] NODE_MAX = 6'h20;
    localparam logic [5:0] NODE_RST = 6'h01;
    localparam logic [15:0] POS_RST = 16'h8000;
    localparam logic [11:0] MID_RST = 12'h800;

    // ****************************************
    // Byte positions in the data field
    // ****************************************
    localparam int BYTE_CMD = 0;
    localparam int BYTE_RW = 2;
    localparam int BYTE_NEWID = 7;

    // ****************************************
    // Current reference scaling (units of 1/4095 N-m)
    // ****************************************
    localparam logic [47:0] KP_MUL = 48'h0000000030D4;
    localparam logic [47:0] KD_MUL = 48'h000000001C20;
    localparam logic [47:0] TFF_MUL = 48'h000000000018;
    localparam logic [13:0] TFF_FULL = 14'h0FFF;
    localparam int GAIN_SHIFT = 16;

    // ****************************************
    // Host register offsets
    // ****************************************
    localparam logic [7:0] REG_TARGET = 8'h00;
    localparam logic [7:0] REG_RAW_ID = 8'h04;
    localparam logic [7:0] REG_DATA_LO = 8'h08;
    localparam logic [7:0] REG_DATA_HI = 8'h0C;
    localparam logic [7:0] REG_MOT_A = 8'h10;
    localparam logic [7:0] REG_MOT_B = 8'h14;
    localparam logic [7:0] REG_MOT_C = 8'h18;
    localparam logic [7:0] REG_CTRL = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_RSP_ID = 8'h24;
    localparam logic [7:0] REG_RSP_LO = 8'h28;
    localparam logic [7:0] REG_RSP_HI = 8'h2C;

    // Host orders
    typedef enum logic [1:0] {NMC_OP_RAW, NMC_OP_ID_READ, NMC_OP_ID_WRITE, NMC_OP_MOTION} nmc_op_e;

    // Identifier of a node on a given base
    function automatic logic [10:0] id_of(input logic [10:0] base, input logic [5:0] node);
        return base + {5'h00, node};
    endfunction

    // One byte of a data field, byte 0 in the low bits
    function automatic logic [7:0] get_byte(input logic [63:0] d, input int idx);
        return d[idx*8 +: 8];
    endfunction

    // Eight bytes of a motion command
    function automatic logic [63:0] pack_motion(input logic [15:0] p, input logic [11:0] v,
                                                input logic [11:0] kp, input logic [11:0] kd,
                                                input logic [11:0] t);
        return {t[7:0], kd[3:0], t[11:8], kd[11:4], kp[7:0], v[3:0], kp[11:8], v[11:4],
                p[7:0], p[15:8]};
    endfunction

endpackage

// file: nmc_link_if.sv
interface nmc_link_if;
    import nmc_pkg::*;

    // Host to drive frame
    logic cmd_valid;
    logic [ID_W-1:0] cmd_id;
    logic [DATA_W-1:0] cmd_data;
    // Drive to host frame
    logic rsp_valid;
    logic [ID_W-1:0] rsp_id;
    logic [DATA_W-1:0] rsp_data;

    modport host (output cmd_valid, output cmd_id, output cmd_data,
                  input rsp_valid, input rsp_id, input rsp_data);
    modport drive (input cmd_valid, input cmd_id, input cmd_data,
                   output rsp_valid, output rsp_id, output rsp_data);
endinterface

// file: nmc_drive.sv
module nmc_drive
    import nmc_pkg::*;
#(
    parameter int TQ_SHIFT = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    nmc_link_if.drive link,
    // Feedback from the motor, raw
    input wire logic [15:0] fb_position,
    input wire logic [11:0] fb_velocity,
    input wire logic [11:0] fb_torque,
    input wire logic signed [15:0] torque_constant,
    // Node identity
    output logic [NODE_W-1:0] node_identifier,
    // Motion targets, raw
    output logic [15:0] target_position,
    output logic [11:0] target_velocity,
    output logic [11:0] position_gain,
    output logic [11:0] velocity_gain,
    output logic [11:0] feedforward_torque,
    output logic motion_update,
    // Torque loop output
    output logic signed [31:0] current_reference
);

    // ****************************************
    // Command decode
    // ****************************************
    logic [7:0] cmd_byte;
    logic [7:0] rw_byte;
    logic [7:0] new_id;
    logic is_node_frame;
    logic hit_id_read;
    logic hit_id_write;
    logic hit_motion;
    logic [NODE_W-1:0] node_q;

    // Fields picked out of the command
    assign cmd_byte = get_byte(link.cmd_data, BYTE_CMD);
    assign rw_byte = get_byte(link.cmd_data, BYTE_RW);
    assign new_id = get_byte(link.cmd_data, BYTE_NEWID);

    // Which command this frame is
    assign is_node_frame = link.cmd_valid && link.cmd_id == id_of(CMD_BASE, node_q)
                           && cmd_byte == NODE_CMD;
    assign hit_id_read = is_node_frame && rw_byte == RW_READ;
    assign hit_id_write = is_node_frame && rw_byte == RW_WRITE
                          && new_id >= {2'h0, NODE_MIN} && new_id <= {2'h0, NODE_MAX};
    assign hit_motion = link.cmd_valid && link.cmd_id == id_of(MOT_BASE, node_q);

    // ****************************************
    // Node identifier
    // ****************************************

    // Stored id, changed only by an in-range write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_q <= NODE_RST;
        end else if (hit_id_write) begin
            node_q <= new_id[NODE_W-1:0];
        end
    end

    assign node_identifier = node_q;

    // ****************************************
    // Reply frames
    // ****************************************
    logic rsp_valid_q;
    logic [ID_W-1:0] rsp_id_q;
    logic [DATA_W-1:0] rsp_data_q;
    logic [ID_W-1:0] own_rpl;

    assign own_rpl = id_of(RPL_BASE, node_q);

    // One reply per accepted command, one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_q <= 1'b0;
            rsp_id_q <= '0;
            rsp_data_q <= '0;
        end else begin
            rsp_valid_q <= hit_id_read || hit_id_write || hit_motion;
            if (hit_id_read) begin
                rsp_id_q <= own_rpl;
                rsp_data_q <= {{5'h00, own_rpl[10:8]}, own_rpl[7:0], 24'h000000,
                               rw_byte, 8'h00, cmd_byte};
            end else if (hit_id_write) begin
                rsp_id_q <= own_rpl;
                rsp_data_q <= link.cmd_data;
            end else if (hit_motion) begin
                rsp_id_q <= id_of(MOT_RPL_BASE, node_q);
                rsp_data_q <= {24'h000000, fb_torque[7:0], fb_velocity[3:0], fb_torque[11:8],
                               fb_velocity[11:4], fb_position[7:0], fb_position[15:8]};
            end
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_id = rsp_id_q;
    assign link.rsp_data = rsp_data_q;

    // ****************************************
    // Motion targets
    // ****************************************
    logic [15:0] pos_q;
    logic [11:0] vel_q;
    logic [11:0] kp_q;
    logic [11:0] kd_q;
    logic [11:0] tff_q;
    logic update_q;

    // Unpack the eight bytes of a motion command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= POS_RST;
            vel_q <= MID_RST;
            kp_q <= 12'h000;
            kd_q <= 12'h000;
            tff_q <= MID_RST;
            update_q <= 1'b0;
        end else begin
            update_q <= hit_motion;
            if (hit_motion) begin
                pos_q <= {link.cmd_data[7:0], link.cmd_data[15:8]};
                vel_q <= {link.cmd_data[23:16], link.cmd_data[31:28]};
                kp_q <= {link.cmd_data[27:24], link.cmd_data[39:32]};
                kd_q <= {link.cmd_data[47:40], link.cmd_data[55:52]};
                tff_q <= {link.cmd_data[51:48], link.cmd_data[63:56]};
            end
        end
    end

    assign target_position = pos_q;
    assign target_velocity = vel_q;
    assign position_gain = kp_q;
    assign velocity_gain = kd_q;
    assign feedforward_torque = tff_q;
    assign motion_update = update_q;

    // ****************************************
    // Current reference
    // ****************************************
    logic signed [47:0] perr;
    logic signed [47:0] verr;
    logic signed [47:0] tffc;
    logic signed [47:0] p_term_q;
    logic signed [47:0] v_term_q;
    logic signed [47:0] t_term_q;
    logic signed [47:0] sum;
    logic signed [47:0] cur_full;
    logic signed [31:0] cur_q;

    // Raw errors: both sides share the same offset, so they cancel
    assign perr = 48'($signed({1'b0, pos_q}) - $signed({1'b0, fb_position}));
    assign verr = 48'($signed({1'b0, vel_q}) - $signed({1'b0, fb_velocity}));
    assign tffc = 48'($signed({1'b0, tff_q, 1'b0}) - $signed(TFF_FULL));

    // Weighted terms, each in 1/4095 N-m
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_term_q <= '0;
            v_term_q <= '0;
            t_term_q <= '0;
        end else begin
            p_term_q <= ($signed({36'h0, kp_q}) * perr * $signed(KP_MUL)) >>> GAIN_SHIFT;
            v_term_q <= ($signed({36'h0, kd_q}) * verr * $signed(KD_MUL)) >>> GAIN_SHIFT;
            t_term_q <= tffc * $signed(TFF_MUL);
        end
    end

    assign sum = p_term_q + v_term_q + t_term_q;
    assign cur_full = (sum * 48'(torque_constant)) >>> TQ_SHIFT;

    // Output current, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_full[31:0];
        end
    end

    assign current_reference = cur_q;

endmodule // nmc_drive

// file: nmc_host.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
module nmc_host
    import nmc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    nmc_link_if.host link
);

    // ****************************************
    // APB handshake
    // ****************************************
    logic access;
    logic wr_en;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_val;
    logic rd_ok;

    assign access = psel && penable && !pready_q;
    assign wr_en = psel && penable && pready_q && pwrite;

    // ****************************************
    // Registers
    // ****************************************
    logic [5:0] target_q;
    logic [10:0] raw_id_q;
    logic [31:0] data_lo_q;
    logic [31:0] data_hi_q;
    logic [31:0] mot_a_q;
    logic [31:0] mot_b_q;
    logic [11:0] mot_c_q;
    logic seen_q;
    logic [10:0] rsp_id_q;
    logic [63:0] rsp_data_q;

    // Software written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_q <= NODE_RST;
            raw_id_q <= '0;
            data_lo_q <= '0;
            data_hi_q <= '0;
            mot_a_q <= '0;
            mot_b_q <= '0;
            mot_c_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                REG_TARGET: target_q <= pwdata[5:0];
                REG_RAW_ID: raw_id_q <= pwdata[10:0];
                REG_DATA_LO: data_lo_q <= pwdata;
                REG_DATA_HI: data_hi_q <= pwdata;
                REG_MOT_A: mot_a_q <= pwdata;
                REG_MOT_B: mot_b_q <= pwdata;
                REG_MOT_C: mot_c_q <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // Reply capture; a new reply wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
            rsp_id_q <= '0;
            rsp_data_q <= '0;
        end else begin
            if (link.rsp_valid) begin
                seen_q <= 1'b1;
                rsp_id_q <= link.rsp_id;
                rsp_data_q <= link.rsp_data;
            end else if (wr_en && paddr == REG_STATUS && pwdata[0]) begin
                seen_q <= 1'b0;
            end
        end
    end

    // Read mux
    always_comb begin
        rd_ok = 1'b1;
        rd_val = '0;
        case (paddr)
            REG_TARGET: rd_val = {26'h0, target_q};
            REG_RAW_ID: rd_val = {21'h0, raw_id_q};
            REG_DATA_LO: rd_val = data_lo_q;
            REG_DATA_HI: rd_val = data_hi_q;
            REG_MOT_A: rd_val = mot_a_q;
            REG_MOT_B: rd_val = mot_b_q;
            REG_MOT_C: rd_val = {20'h0, mot_c_q};
            REG_CTRL: rd_val = '0;
            REG_STATUS: rd_val = {31'h0, seen_q};
            REG_RSP_ID: rd_val = {21'h0, rsp_id_q};
            REG_RSP_LO: rd_val = rsp_data_q[31:0];
            REG_RSP_HI: rd_val = rsp_data_q[63:32];
            default: rd_ok = 1'b0;
        endcase
    end

    // One wait state, then answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !rd_ok;
            prdata_q <= (access && !pwrite) ? rd_val : 32'h00000000;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ****************************************
    // Frame builder
    // ****************************************
    logic cmd_valid_q;
    logic [10:0] cmd_id_q;
    logic [63:0] cmd_data_q;
    nmc_op_e op;

    assign op = nmc_op_e'(pwdata[1:0]);

    // A write to the control word sends one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid_q <= 1'b0;
            cmd_id_q <= '0;
            cmd_data_q <= '0;
        end else begin
            cmd_valid_q <= wr_en && paddr == REG_CTRL;
            if (wr_en && paddr == REG_CTRL) begin
                case (op)
                    NMC_OP_RAW: begin
                        cmd_id_q <= raw_id_q;
                        cmd_data_q <= {data_hi_q, data_lo_q};
                    end
                    NMC_OP_ID_READ: begin
                        cmd_id_q <= id_of(CMD_BASE, target_q);
                        cmd_data_q <= {40'h0, RW_READ, 8'h00, NODE_CMD};
                    end
                    NMC_OP_ID_WRITE: begin
                        cmd_id_q <= id_of(CMD_BASE, target_q);
                        cmd_data_q <= {2'h0, pwdata[13:8], 32'h0, RW_WRITE, 8'h00, NODE_CMD};
                    end
                    NMC_OP_MOTION: begin
                        cmd_id_q <= id_of(MOT_BASE, target_q);
                        cmd_data_q <= pack_motion(mot_a_q[15:0], mot_a_q[27:16], mot_b_q[11:0],
                                                  mot_b_q[27:16], mot_c_q);
                    end
                    default: cmd_valid_q <= 1'b0;
                endcase
            end
        end
    end

    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_id = cmd_id_q;
    assign link.cmd_data = cmd_data_q;

endmodule // nmc_host

// file: nmc_sva.sv
module nmc_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host to drive
    input wire logic cmd_valid,
    input wire logic [10:0] cmd_id,
    input wire logic [63:0] cmd_data,
    // Drive to host
    input wire logic rsp_valid,
    input wire logic [10:0] rsp_id,
    input wire logic [63:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [5:0] node_q;
    logic id_hit, is_rd, wr_ok, mot_hit;

    // Frame decode against the tracked node
    assign id_hit = cmd_valid && cmd_id == 11'h140 + {5'h00, node_q} && cmd_data[7:0] == 8'h79;
    assign is_rd = id_hit && cmd_data[23:16] == 8'h01;
    assign wr_ok = id_hit && cmd_data[23:16] == 8'h00 && cmd_data[63:56] >= 8'h01 && cmd_data[63:56] <= 8'h20;
    assign mot_hit = cmd_valid && cmd_id == 11'h400 + {5'h00, node_q};

    // Node seen from the wire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_q <= 6'h01;
        end else if (wr_ok) begin
            node_q <= cmd_data[61:56];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // Assertions
    // ****************************************
    a_read_reply: assert property (is_rd |=> rsp_valid && rsp_id == 11'h240 + {5'h00, node_q} &&
        rsp_data == {8'h02, 8'h40 + {2'b00, node_q}, 24'h000000, 8'h01, 8'h00, 8'h79})
        else $error("read reply wrong");
    a_write_echo: assert property (wr_ok |=> rsp_valid && rsp_data == $past(cmd_data) &&
        rsp_id == 11'h240 + {5'h00, $past(node_q)})
        else $error("write reply wrong");
    a_refused_quiet: assert property (cmd_valid && !is_rd && !wr_ok && !mot_hit |=> !rsp_valid)
        else $error("reply to refused frame");
    a_motion_reply: assert property (mot_hit |=> rsp_valid && rsp_id == 11'h500 + {5'h00, node_q} &&
        rsp_data[63:40] == 24'h000000)
        else $error("motion reply wrong");
    a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("reply without command");
    a_rsp_pulse: assert property (rsp_valid && !cmd_valid |=> !rsp_valid)
        else $error("reply longer than one cycle");
    a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_id) && $stable(rsp_data))
        else $error("reply fields moved");
    a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command longer than one cycle");
    a_unused_zero: assert property (cmd_valid && cmd_id[10:8] == 3'h1 && cmd_data[7:0] == 8'h79 |->
        cmd_data[15:8] == 8'h00 && cmd_data[55:24] == 32'h0)
        else $error("unused byte not zero");

    // Main scenarios
    c_read: cover property (is_rd);
    c_write: cover property (wr_ok);
    c_motion: cover property (mot_hit);
endmodule // nmc_sva

// file: node_id_and_motion_frame_codec_tb.sv
module node_id_and_motion_frame_codec_tb
    import nmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, motion_update;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] fb_position, target_position;
    logic [11:0] fb_velocity, fb_torque, target_velocity, position_gain, velocity_gain, feedforward_torque;
    logic signed [15:0] torque_constant;
    logic signed [31:0] current_reference;
    logic [NODE_W-1:0] node_identifier;
    logic [10:0] last_id, cmd_id_seen;
    logic [63:0] last_data, cmd_data_seen;
    int failures, n_checks, cycles, n_rsp, n_upd;

    nmc_link_if link();
    nmc_host nmc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    nmc_drive nmc_drive_inst (.pclk(pclk), .presetn(presetn), .link(link), .fb_position(fb_position),
        .fb_velocity(fb_velocity), .fb_torque(fb_torque), .torque_constant(torque_constant),
        .node_identifier(node_identifier), .target_position(target_position), .target_velocity(target_velocity),
        .position_gain(position_gain), .velocity_gain(velocity_gain), .feedforward_torque(feedforward_torque),
        .motion_update(motion_update), .current_reference(current_reference));
    nmc_sva nmc_sva_inst (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid), .cmd_id(link.cmd_id),
        .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_id(link.rsp_id), .rsp_data(link.rsp_data));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Link monitor and timeout
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (link.rsp_valid === 1'b1) begin
            n_rsp <= n_rsp + 1;
            last_id <= link.rsp_id;
            last_data <= link.rsp_data;
        end
        if (link.cmd_valid === 1'b1) begin
            cmd_id_seen <= link.cmd_id;
            cmd_data_seen <= link.cmd_data;
        end
        if (motion_update === 1'b1) n_upd <= n_upd + 1;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer, held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold until the edge that samples pready high; take the answer there
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        xfer(1'b0, a, 32'h0, rd, err);
        chk(what, {32'h0, exp}, {32'h0, rd});
        chk("pslverr", 64'h0, {63'h0, err});
    endtask

    // Send one frame and judge the reply
    task automatic frame(input logic [31:0] ctrl, input logic rep, input logic [10:0] id, input logic [63:0] d);
        int b;
        b = n_rsp;
        wr(REG_CTRL, ctrl);
        repeat (4) @(posedge pclk);
        chk("reply count", {63'h0, rep}, 64'(n_rsp - b));
        if (rep) begin
            chk("reply id", {53'h0, id}, {53'h0, last_id});
            chk("reply data", d, last_data);
        end
    endtask

    task automatic t_reset();
        logic [31:0] rd;
        logic err;
        chk("node", 64'h1, {58'h0, node_identifier});
        chk("targets", {16'h8000, 12'h800, 24'h0, 12'h800}, {target_position, target_velocity, position_gain,
            velocity_gain, feedforward_torque});
        rd_chk("target reg", REG_TARGET, 32'h1);
        xfer(1'b0, 8'h30, 32'h0, rd, err);
        chk("unmapped", 64'h1_0000_0000, {31'h0, err, rd});
        $display("test reset done");
    endtask

    task automatic t_id_read();
        frame(32'h1, 1'b1, 11'h241, 64'h0241_0000_0001_0079);
        chk("cmd id", 64'h141, {53'h0, cmd_id_seen});
        chk("cmd data", 64'h0000_0000_0001_0079, cmd_data_seen);
        rd_chk("rsp id", REG_RSP_ID, 32'h241);
        rd_chk("rsp lo", REG_RSP_LO, 32'h0001_0079);
        rd_chk("rsp hi", REG_RSP_HI, 32'h0241_0000);
        rd_chk("status", REG_STATUS, 32'h1);
        wr(REG_STATUS, 32'h1);
        rd_chk("status clr", REG_STATUS, 32'h0);
        $display("test id read done");
    endtask

    task automatic t_id_write();
        frame(32'h2002, 1'b1, 11'h241, 64'h2000_0000_0000_0079);
        chk("node", 64'h20, {58'h0, node_identifier});
        frame(32'h1, 1'b0, 11'h0, 64'h0);
        wr(REG_TARGET, 32'h20);
        frame(32'h0002, 1'b0, 11'h0, 64'h0);
        frame(32'h2102, 1'b0, 11'h0, 64'h0);
        chk("node kept", 64'h20, {58'h0, node_identifier});
        frame(32'h1, 1'b1, 11'h260, 64'h0260_0000_0001_0079);
        frame(32'h0202, 1'b1, 11'h260, 64'h0200_0000_0000_0079);
        chk("node", 64'h2, {58'h0, node_identifier});
        wr(REG_TARGET, 32'h2);
        $display("test id write done");
    endtask

    task automatic t_refuse();
        wr(REG_RAW_ID, 32'h142);
        wr(REG_DATA_HI, 32'h0);
        wr(REG_DATA_LO, 32'h0002_0079);
        frame(32'h0, 1'b0, 11'h0, 64'h0);
        wr(REG_DATA_LO, 32'h0001_0078);
        frame(32'h0, 1'b0, 11'h0, 64'h0);
        wr(REG_DATA_LO, 32'h0001_0079);
        wr(REG_RAW_ID, 32'h300);
        frame(32'h0, 1'b0, 11'h0, 64'h0);
        $display("test refuse done");
    endtask

    task automatic t_motion();
        int b;
        b = n_upd;
        wr(REG_RAW_ID, 32'h402);
        wr(REG_DATA_LO, 32'hE082_65E6);
        wr(REG_DATA_HI, 32'h553B_3352);
        frame(32'h0, 1'b1, 11'h502, 64'h0000_0055_EB82_65E6);
        chk("targets", {16'hE665, 12'h82E, 12'h052, 12'h333, 12'hB55}, {target_position, target_velocity,
            position_gain, velocity_gain, feedforward_torque});
        chk("updates", 64'h1, 64'(n_upd - b));
        repeat (4) @(posedge pclk);
        chk("current", 64'd40968, 64'(current_reference));
        wr(REG_MOT_A, 32'h0ABC_1234);
        wr(REG_MOT_B, 32'h0135_0DEF);
        wr(REG_MOT_C, 32'h79A);
        frame(32'h3, 1'b1, 11'h502, 64'h0000_0055_EB82_65E6);
        chk("cmd id", 64'h402, {53'h0, cmd_id_seen});
        chk("cmd data", 64'h9A57_13EF_CDAB_3412, cmd_data_seen);
        chk("targets", {16'h1234, 12'hABC, 12'hDEF, 12'h135, 12'h79A}, {target_position, target_velocity,
            position_gain, velocity_gain, feedforward_torque});
        repeat (4) @(posedge pclk);
        chk("current gains", -64'sd36940032, 64'(current_reference));
        $display("test motion done");
    endtask

    // Main sequence
    initial begin
        {failures, n_checks, cycles, n_rsp, n_upd} = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        fb_position = 16'hE665;
        fb_velocity = 12'h82E;
        fb_torque = 12'hB55;
        torque_constant = 16'sh1000;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_id_read();
        t_id_write();
        t_refuse();
        t_motion();
        close_out();
    end
endmodule // node_id_and_motion_frame_codec_tb
